// [hw/spacr_map.vh]
// What this block does
// - Mirrored bits 7,0 select data pin direction
// - Mirrored bits 6,1 select LSB-first order
// - Soft reset rise restores all but port setup
// - Two-bit select picks I, Q, both, none
// - Converter writes staged, applied on update rise
// - Buffer bit 1 drives common-mode output enable
// - Six-bit offset added to converter samples
// - Negative offset codes are two's complement
`ifndef SPACR_MAP_VH
`define SPACR_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPACR_ADDR_SETUP   8'h00
`define SPACR_ADDR_SELECT  8'h05
`define SPACR_ADDR_CMBUF   8'h0f
`define SPACR_ADDR_OFFSET  8'h10
`define SPACR_ADDR_UPDATE  8'hff
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPACR_SETUP_DIR_HI  7
`define SPACR_SETUP_DIR_LO  0
`define SPACR_SETUP_LSB_HI  6
`define SPACR_SETUP_LSB_LO  1
`define SPACR_SETUP_RST_HI  5
`define SPACR_SETUP_RST_LO  2
`define SPACR_SEL_I         0
`define SPACR_SEL_Q         1
`define SPACR_CMBUF_EN      1
`define SPACR_UPDATE_BIT    0
`define SPACR_OFF_HI        5
`define SPACR_OFF_LO        0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPACR_RST_SETUP   8'h00
`define SPACR_RST_SELECT  8'h03
`define SPACR_RST_CMBUF   8'h00
`define SPACR_RST_OFFSET  8'h00
`define SPACR_RST_UPDATE  8'h00
`define SPACR_RST_FLAG    1'b0
`define SPACR_RST_OFFCODE 6'h00
`define SPACR_RST_UNMAPPED 8'h00
`define SPACR_SETUP_SRST_MASK 8'h24
`endif

// [hw/spacr_offset_add.v]
`timescale 1ns/1ns
`default_nettype none
`include "spacr_map.vh"
// Adds signed six-bit offset, saturating at the sample range
module spacr_offset_add #(
    parameter SW = 12
) (
    // Sample path
    input  wire          clk,
    input  wire [SW-1:0] sample_in,
    input  wire [5:0]    offset_code,
    output wire [SW-1:0] sample_out
);
    wire signed [SW+1:0] sum;
    wire signed [SW+1:0] max_v;
    wire signed [SW+1:0] min_v;
    reg         [SW-1:0] nxt_sample;
    reg         [SW-1:0] sample_ff;

    assign max_v = $signed({2'b00, 1'b0, {(SW-1){1'b1}}});
    assign min_v = $signed({2'b11, 1'b1, {(SW-1){1'b0}}});
    // Sign extend both; code 100000 gives -32
    assign sum = $signed({{2{sample_in[SW-1]}}, sample_in})
               + $signed({{(SW+1-`SPACR_OFF_HI){offset_code[`SPACR_OFF_HI]}},
                          offset_code});

    // Clamp rather than wrap, so a large offset cannot flip the sign
    always @* begin
        if (sum > max_v) begin
            nxt_sample = max_v[SW-1:0];
        end else if (sum < min_v) begin
            nxt_sample = min_v[SW-1:0];
        end else begin
            nxt_sample = sum[SW-1:0];
        end
    end

    always @(posedge clk) begin
        sample_ff <= nxt_sample;
    end

    assign sample_out = sample_ff;
endmodule // spacr_offset_add
`default_nettype wire

// [hw/spacr_regs.v]
`timescale 1ns/1ns
`default_nettype none
`include "spacr_map.vh"
module spacr_regs #(
    parameter SW = 12
) (
    // Clock and reset
    input  wire          CLK,
    input  wire          RST,
    // Register port from the serial shifter
    input  wire          WR_STB,
    input  wire [7:0]    ADDR,
    input  wire [7:0]    WDATA,
    output wire [7:0]    RDATA,
    // Port setup
    output wire          DATA_PIN_INPUT_ONLY,
    output wire          LSB_FIRST,
    // Common-mode output enables
    output wire          I_RECEIVE_COMMON_MODE_OUT_OE,
    output wire          Q_RECEIVE_COMMON_MODE_OUT_OE,
    // Converter samples
    input  wire [SW-1:0] I_SAMPLE_IN,
    input  wire [SW-1:0] Q_SAMPLE_IN,
    output wire [SW-1:0] I_SAMPLE_OUT,
    output wire [SW-1:0] Q_SAMPLE_OUT
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg  [7:0] setup_ff;
    reg  [7:0] select_ff;
    reg  [7:0] cmbuf_stage_ff;
    reg  [7:0] offset_stage_ff;
    reg  [7:0] update_ff;
    reg        cm_i_ff;
    reg        cm_q_ff;
    reg  [5:0] off_i_ff;
    reg  [5:0] off_q_ff;
    reg        stage_cm_ff;
    reg        stage_off_ff;
    reg        dir_ff;
    reg        lsb_ff;
    reg  [7:0] rdata_ff;
    reg  [7:0] nxt_setup;
    reg  [7:0] nxt_rdata;
    wire       wr_setup;
    wire       wr_select;
    wire       wr_cmbuf;
    wire       wr_offset;
    wire       wr_update;
    wire       srst_rise;
    wire       upd_rise;
    wire       inphase_converter_select;
    wire       quad_converter_select;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // One decoder for every strobe keeps the offsets in one place
    function addr_hit;
        input       stb;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = stb && (addr == target);
        end
    endfunction

    // Either copy of a mirrored pair counts, whatever the bit order
    function pair_any;
        input [7:0]   word;
        input integer hi;
        input integer lo;
        begin
            pair_any = word[hi] | word[lo];
        end
    endfunction

    // Low-to-high on either copy of a pair
    function pair_rise;
        input [7:0]   now_word;
        input [7:0]   old_word;
        input integer hi;
        input integer lo;
        begin
            pair_rise = (now_word[hi] && !old_word[hi])
                     || (now_word[lo] && !old_word[lo]);
        end
    endfunction

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign wr_setup  = addr_hit(WR_STB, ADDR, `SPACR_ADDR_SETUP);
    assign wr_select = addr_hit(WR_STB, ADDR, `SPACR_ADDR_SELECT);
    assign wr_cmbuf  = addr_hit(WR_STB, ADDR, `SPACR_ADDR_CMBUF);
    assign wr_offset = addr_hit(WR_STB, ADDR, `SPACR_ADDR_OFFSET);
    assign wr_update = addr_hit(WR_STB, ADDR, `SPACR_ADDR_UPDATE);
    // Stored reset bits are always 0, so any write with one set fires
    assign srst_rise = wr_setup
        && pair_rise(WDATA, setup_ff, `SPACR_SETUP_RST_HI, `SPACR_SETUP_RST_LO);
    assign upd_rise  = wr_update
        && pair_rise(WDATA, update_ff, `SPACR_UPDATE_BIT, `SPACR_UPDATE_BIT);
    assign inphase_converter_select = select_ff[`SPACR_SEL_I];
    assign quad_converter_select    = select_ff[`SPACR_SEL_Q];

    // ----------------------------------------
    // Port setup, mirrored pairs
    // ----------------------------------------
    // Reset bits never stick, so a later write can fire again
    always @* begin
        nxt_setup = setup_ff;
        if (wr_setup) begin
            nxt_setup = WDATA & ~`SPACR_SETUP_SRST_MASK;
        end
    end

    // Pin direction and bit order leave straight from flops
    always @(posedge CLK) begin
        if (RST) begin
            setup_ff <= `SPACR_RST_SETUP;
            dir_ff   <= `SPACR_RST_FLAG;
            lsb_ff   <= `SPACR_RST_FLAG;
        end else begin
            setup_ff <= nxt_setup;
            dir_ff   <= pair_any(nxt_setup, `SPACR_SETUP_DIR_HI,
                                 `SPACR_SETUP_DIR_LO);
            lsb_ff   <= pair_any(nxt_setup, `SPACR_SETUP_LSB_HI,
                                 `SPACR_SETUP_LSB_LO);
        end
    end

    assign DATA_PIN_INPUT_ONLY = dir_ff;
    assign LSB_FIRST           = lsb_ff;

    // ----------------------------------------
    // Other registers; soft reset spares port setup
    // ----------------------------------------
    always @(posedge CLK) begin
        if (RST || srst_rise) begin
            select_ff       <= `SPACR_RST_SELECT;
            cmbuf_stage_ff  <= `SPACR_RST_CMBUF;
            offset_stage_ff <= `SPACR_RST_OFFSET;
            update_ff       <= `SPACR_RST_UPDATE;
            cm_i_ff         <= `SPACR_RST_FLAG;
            cm_q_ff         <= `SPACR_RST_FLAG;
            off_i_ff        <= `SPACR_RST_OFFCODE;
            off_q_ff        <= `SPACR_RST_OFFCODE;
            stage_cm_ff     <= `SPACR_RST_FLAG;
            stage_off_ff    <= `SPACR_RST_FLAG;
        end else begin
            if (wr_select) begin
                select_ff <= WDATA;
            end
            if (wr_cmbuf) begin
                cmbuf_stage_ff <= WDATA;
                stage_cm_ff    <= 1'b1;
            end
            if (wr_offset) begin
                offset_stage_ff <= WDATA;
                stage_off_ff    <= 1'b1;
            end
            if (wr_update) begin
                update_ff <= WDATA;
            end
            // Staged values reach only the selected converters
            if (upd_rise) begin
                stage_cm_ff  <= 1'b0;
                stage_off_ff <= 1'b0;
                if (stage_cm_ff && inphase_converter_select) begin
                    cm_i_ff <= cmbuf_stage_ff[`SPACR_CMBUF_EN];
                end
                if (stage_cm_ff && quad_converter_select) begin
                    cm_q_ff <= cmbuf_stage_ff[`SPACR_CMBUF_EN];
                end
                if (stage_off_ff && inphase_converter_select) begin
                    off_i_ff <= offset_stage_ff[`SPACR_OFF_HI:`SPACR_OFF_LO];
                end
                if (stage_off_ff && quad_converter_select) begin
                    off_q_ff <= offset_stage_ff[`SPACR_OFF_HI:`SPACR_OFF_LO];
                end
            end
        end
    end

    assign I_RECEIVE_COMMON_MODE_OUT_OE = cm_i_ff;
    assign Q_RECEIVE_COMMON_MODE_OUT_OE = cm_q_ff;

    // ----------------------------------------
    // Readback
    // ----------------------------------------
    // Registered: RDATA shows ADDR one edge after the address is set
    always @* begin
        nxt_rdata = `SPACR_RST_UNMAPPED;
        case (ADDR)
            `SPACR_ADDR_SETUP: begin
                nxt_rdata = setup_ff;
            end
            `SPACR_ADDR_SELECT: begin
                nxt_rdata = select_ff;
            end
            `SPACR_ADDR_CMBUF: begin
                nxt_rdata[`SPACR_CMBUF_EN] = cm_i_ff | cm_q_ff;
            end
            `SPACR_ADDR_OFFSET: begin
                // One field for two converters: Q only when Q alone is chosen
                if (quad_converter_select && !inphase_converter_select) begin
                    nxt_rdata[`SPACR_OFF_HI:`SPACR_OFF_LO] = off_q_ff;
                end else begin
                    nxt_rdata[`SPACR_OFF_HI:`SPACR_OFF_LO] = off_i_ff;
                end
            end
            `SPACR_ADDR_UPDATE: begin
                nxt_rdata = update_ff;
            end
            default: begin
                nxt_rdata = `SPACR_RST_UNMAPPED;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (RST) begin
            rdata_ff <= `SPACR_RST_UNMAPPED;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;

    // ----------------------------------------
    // Sample offset paths
    // ----------------------------------------
    spacr_offset_add #(.SW(SW)) u_off_i (
        .clk         (CLK),
        .sample_in   (I_SAMPLE_IN),
        .offset_code (off_i_ff),
        .sample_out  (I_SAMPLE_OUT)
    );
    spacr_offset_add #(.SW(SW)) u_off_q (
        .clk         (CLK),
        .sample_in   (Q_SAMPLE_IN),
        .offset_code (off_q_ff),
        .sample_out  (Q_SAMPLE_OUT)
    );
endmodule // spacr_regs
`default_nettype wire

// [test/spacr_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module spacr_checker (
    // DUT ports
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       WR_STB,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic       DATA_PIN_INPUT_ONLY,
    input wire logic       LSB_FIRST,
    input wire logic       I_RECEIVE_COMMON_MODE_OUT_OE,
    input wire logic       Q_RECEIVE_COMMON_MODE_OUT_OE
);
    wire       w0 = WR_STB && ADDR == 8'h00;
    wire       wu = WR_STB && ADDR == 8'hff;
    wire       sr = w0 && (WDATA[5] || WDATA[2]);
    wire       pd = WDATA[7] || WDATA[0];
    wire       pl = WDATA[6] || WDATA[1];
    wire [1:0] oe = {Q_RECEIVE_COMMON_MODE_OUT_OE, I_RECEIVE_COMMON_MODE_OUT_OE};
    logic [1:0] sel_ff;
    // Shadow select, soft reset included
    always_ff @(posedge CLK) begin
        if (RST || sr) begin
            sel_ff <= 2'h3;
        end else if (WR_STB && ADDR == 8'h05) begin
            sel_ff <= WDATA[1:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_dir; w0 |=> DATA_PIN_INPUT_ONLY == $past(pd); endproperty
    a_dir: assert property (p_dir) else $error("dir");
    property p_lsb; w0 |=> LSB_FIRST == $past(pl); endproperty
    a_lsb: assert property (p_lsb) else $error("lsb");
    property p_srst; sr |=> oe == 2'h0; endproperty
    a_srst: assert property (p_srst) else $error("srst");
    property p_hold; !wu && !sr |=> $stable(oe); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_none; wu && sel_ff == 2'h0 |=> $stable(oe); endproperty
    a_none: assert property (p_none) else $error("none");
    property p_qo; wu && sel_ff == 2'h2 |=> $stable(oe[0]); endproperty
    a_qo: assert property (p_qo) else $error("qo");
    property p_io; wu && sel_ff == 2'h1 |=> $stable(oe[1]); endproperty
    a_io: assert property (p_io) else $error("io");
    property p_clr; ADDR == 8'h00 |=> !RDATA[5] && !RDATA[2]; endproperty
    a_clr: assert property (p_clr) else $error("clr");
endmodule // spacr_checker
bind spacr_regs spacr_checker i_chk (.CLK, .RST, .WR_STB, .ADDR, .WDATA, .RDATA,
    .DATA_PIN_INPUT_ONLY, .LSB_FIRST, .I_RECEIVE_COMMON_MODE_OUT_OE,
    .Q_RECEIVE_COMMON_MODE_OUT_OE);
`default_nettype wire

// [test/spacr_host.sv]
`timescale 1ns/1ns
`default_nettype none
module spacr_host (
    // Register port
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output var  logic       wr_stb = 1'h0,
    output var  logic [7:0] addr = 8'h00,
    output var  logic [7:0] wdata = 8'h00
);
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        {wr_stb, addr, wdata} = {1'h1, a, d};
        @(negedge clk);
        wr_stb = 1'h0;
        wdata = ~d; // Stale byte flipped once released
    endtask
    task automatic upd();
        wr(8'hff, 8'h00);
        wr(8'hff, 8'h01);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        @(negedge clk); // Readback is registered, one edge behind
        d = rdata;
    endtask
endmodule // spacr_host
`default_nettype wire

// [test/tb_serial_port_adc_config_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_serial_port_adc_config_regs;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic wr_stb, dir, lsb, oe_i, oe_q;
    logic [7:0] addr, wdata, rdata, rb;
    logic [11:0] out_i, out_q;
    logic [11:0] smp_i = 12'h064;
    logic [11:0] smp_q = 12'h064;
    int n_fail = 0;
    int num_checks = 0;
    initial begin
        forever #50 clk = ~clk;
    end
    spacr_host i_host (.clk(clk), .rdata(rdata), .wr_stb(wr_stb), .addr(addr), .wdata(wdata));
    spacr_regs #(.SW(12)) i_dut (.CLK(clk), .RST(rst), .WR_STB(wr_stb), .ADDR(addr),
        .WDATA(wdata), .RDATA(rdata), .DATA_PIN_INPUT_ONLY(dir), .LSB_FIRST(lsb),
        .I_RECEIVE_COMMON_MODE_OUT_OE(oe_i), .Q_RECEIVE_COMMON_MODE_OUT_OE(oe_q),
        .I_SAMPLE_IN(smp_i), .Q_SAMPLE_IN(smp_q), .I_SAMPLE_OUT(out_i), .Q_SAMPLE_OUT(out_q));
    task automatic chk(input string n, input logic [11:0] g, e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic t_setup();
        logic [7:0] v[5] = '{8'h01, 8'h80, 8'h02, 8'h40, 8'h00};
        logic [1:0] e[5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
        for (int k = 0; k < 5; k++) begin
            i_host.wr(8'h00, v[k]);
            chk("setup", {dir, lsb}, e[k]);
        end
        $display("t_setup end");
    endtask
    task automatic t_offset();
        logic [5:0] c[5] = '{6'h1f, 6'h01, 6'h00, 6'h3f, 6'h20};
        i_host.wr(8'h05, 8'h01);
        for (int k = 0; k < 5; k++) begin
            i_host.wr(8'h10, {2'h0, c[k]});
            i_host.upd();
            @(negedge clk);
            chk("off_i", out_i, 12'h064 + {{6{c[k][5]}}, c[k]});
            chk("off_q", out_q, 12'h064);
        end
        i_host.wr(8'h10, 8'h05);
        @(negedge clk);
        chk("staged", out_i, 12'h044);
        $display("t_offset end");
    endtask
    task automatic t_cm();
        logic [7:0] s[4] = '{8'h02, 8'h03, 8'h00, 8'h01};
        logic [7:0] v[4] = '{8'h02, 8'h02, 8'h00, 8'h01};
        logic [1:0] e[4] = '{2'h2, 2'h3, 2'h3, 2'h2};
        for (int k = 0; k < 4; k++) begin
            i_host.wr(8'h05, s[k]);
            i_host.wr(8'h0f, v[k]);
            if (k == 0) begin
                chk("cm_stage", {oe_q, oe_i}, 2'h0);
            end
            i_host.upd();
            chk("cm", {oe_q, oe_i}, e[k]);
        end
        $display("t_cm end");
    endtask
    task automatic t_sat();
        smp_i = 12'h7f0;
        smp_q = 12'h800;
        i_host.wr(8'h05, 8'h03);
        i_host.wr(8'h10, 8'h1f);
        i_host.upd();
        @(negedge clk);
        chk("sat_hi", out_i, 12'h7ff);
        chk("both_q", out_q, 12'h81f);
        i_host.wr(8'h05, 8'h02);
        i_host.wr(8'h10, 8'h3f);
        i_host.upd();
        @(negedge clk);
        chk("sat_lo", out_q, 12'h800);
        chk("keep_i", out_i, 12'h7ff);
        i_host.rd(8'h10, rb);
        chk("rd_off", rb, 8'h3f);
        i_host.rd(8'h0f, rb);
        chk("rd_cm", rb, 8'h02);
        i_host.rd(8'hff, rb);
        chk("rd_upd", rb, 8'h01);
        smp_i = 12'h064;
        smp_q = 12'h064;
        $display("t_sat end");
    endtask
    task automatic t_srst();
        i_host.wr(8'h00, 8'ha5);
        chk("srst_oe", {oe_q, oe_i}, 2'h0);
        chk("srst_keep", {dir, lsb}, 2'h2);
        i_host.rd(8'h05, rb);
        chk("srst_sel", rb, 8'h03);
        i_host.rd(8'h00, rb);
        chk("srst_clr", rb, 8'h81);
        i_host.rd(8'h33, rb);
        chk("unmapped", rb, 8'h00);
        chk("srst_off", out_i, 12'h064);
        i_host.wr(8'h05, 8'h01);
        i_host.wr(8'h00, 8'h24);
        i_host.rd(8'h05, rb);
        chk("srst_again", rb, 8'h03);
        $display("t_srst end");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'h0;
        t_setup();
        t_offset();
        t_cm();
        t_sat();
        t_srst();
        summarize();
    end
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule // tb_serial_port_adc_config_regs
`default_nettype wire
